// >>> rtl/scc_pkg.sv
// Constants, register map and types of the synchroniser control I/O block
package scc_pkg;
  // Clock and timing
  localparam int CLK_NS     = 8;
  localparam int TICK_US    = 100;
  localparam int STORE_MS   = 30;
  localparam int SETTLE_MS  = 1000;
  localparam int HOLD_MS    = 1;
  localparam int TICK_CYC   = (TICK_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int STORE_CYC  = (STORE_MS * 1000000 + CLK_NS - 1) / CLK_NS;
  localparam int SETTLE_CYC = (SETTLE_MS * 1000000) / CLK_NS;
  localparam int HOLD_CYC   = (HOLD_MS * 1000000 + CLK_NS - 1) / CLK_NS;
  // Widths
  localparam int AW     = 5;
  localparam int DW     = 16;
  localparam int DIFF_W = 24;
  localparam int CNT_W  = 27;
  localparam int TICK_W = 14;
  localparam int NPIN   = 10;
  // Parameter words, all held in the nonvolatile store
  localparam logic [2:0] P_CTRL   = 3'h0;
  localparam logic [2:0] P_FACTOR = 3'h1;
  localparam logic [2:0] P_TRIM   = 3'h2;
  localparam logic [2:0] P_TOL    = 3'h3;
  localparam logic [2:0] P_WIN    = 3'h4;
  localparam logic [2:0] P_PHASE  = 3'h5;
  localparam logic [2:0] P_LIMIT  = 3'h6;
  localparam logic [2:0] P_SPARE  = 3'h7;
  localparam logic [7:0][15:0] PRM_DEF = {16'h0000, 16'h07FF, 16'h0000, 16'h000A,
                                          16'h001E, 16'h0001, 16'h2710, 16'h0000};
  // Status and command registers
  localparam logic [4:0] R_STATUS  = 5'h08;
  localparam logic [4:0] R_DIFF    = 5'h09;
  localparam logic [4:0] R_IRQ_ST  = 5'h0A;
  localparam logic [4:0] R_IRQ_CLR = 5'h0B;
  localparam logic [4:0] R_IRQ_EN  = 5'h0C;
  localparam logic [4:0] R_CMD     = 5'h0D;
  // Control word fields
  localparam int C_MODE_LO  = 0;
  localparam int C_MARK_EN  = 3;
  localparam int C_MREV     = 4;
  localparam int C_SREV     = 5;
  localparam logic [2:0] MODE_RATIO = 3'h4;
  // Trim period limits in 100 us cycles
  localparam logic [15:0] TRIM_MIN = 16'h0001;
  localparam logic [15:0] TRIM_MAX = 16'h03E7;
  // Store layout: eight words then a validity mark (value arbitrary)
  localparam logic [3:0]  SIG_ADDR  = 4'h8;
  localparam logic [15:0] STORE_SIG = 16'h5AC3;
  localparam logic [3:0]  BOOT_LAST = 4'h9;
  // Interrupt bits
  localparam int I_ALARM = 0;
  localparam int I_LOST  = 1;
  localparam int I_MARK  = 2;
  localparam int I_STORE = 3;
  // Sequencer states
  typedef enum logic [3:0] {
    ST_BOOT   = 4'b0001,
    ST_SETTLE = 4'b0010,
    ST_RUN    = 4'b0100,
    ST_STORE  = 4'b1000
  } scc_fsm_t;
endpackage : scc_pkg

// >>> rtl/scc_sync.sv
// Two-stage synchroniser for the discrete input pins
`timescale 1ns/1ns
module scc_sync #(
  parameter int W = 10
) (
  input  wire logic         core_clk, // System clock
  input  wire logic         rst,      // Synchronous reset
  input  wire logic [W-1:0] din,      // Asynchronous pins
  output logic      [W-1:0] dout      // Synchronised levels
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } scc_sync_t;
  scc_sync_t s, next_s;

  // Second stage reads the first and nothing else
  always_comb begin
    next_s      = s;
    next_s.meta = din;
    next_s.sync = s.meta;
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign dout = s.sync;

  a_sync_two_stage: assert property (@(posedge core_clk) disable iff (rst) // see RULE17
    !$past(rst, 2) |-> dout == $past(din, 2))
    else $error("synchroniser delay is not two cycles");
endmodule : scc_sync

// >>> rtl/scc_nvmem.sv
// Parameter store standing for the nonvolatile memory
`timescale 1ns/1ns
module scc_nvmem (
  input  wire logic        core_clk, // System clock
  input  wire logic        we,       // Write enable
  input  wire logic [3:0]  waddr,    // Write address
  input  wire logic [15:0] wdata,    // Write data
  input  wire logic [3:0]  raddr,    // Read address
  output logic      [15:0] rdata     // Registered read data
);
  typedef struct packed {
    logic [15:0][15:0] word;
    logic [15:0]       rd;
  } scc_mem_t;
  scc_mem_t s, next_s;

  // Contents survive reset on purpose
  always_comb begin
    next_s    = s;
    next_s.rd = s.word[raddr];
    if (we) begin
      next_s.word[waddr] = wdata;
    end
  end

  // State register, no reset
  always_ff @(posedge core_clk) begin
    s <= next_s;
  end

  assign rdata = s.rd;

  a_mem_write_kept: assert property (@(posedge core_clk) // see RULE6
    we |=> s.word[$past(waddr)] == $past(wdata))
    else $error("stored word not kept");
endmodule : scc_nvmem

// >>> rtl/scc_control_io.sv
// Discrete control inputs and status outputs of the drive synchroniser
// Function
// RULE1: The controller holds each command input steady for at least 1 ms.
// RULE2: Advance trim moves the slave ahead of the master, retard trim behind it.
// RULE3: Marker inputs act on rising edges only, and only when enabled. In mode 4 the code steps the ratio factor on held marker levels.
// RULE4: In mode 4 the master and slave markers raise and lower the ratio factor.
// RULE5: The reset input zeroes difference and correction and holds them while high.
// RULE6: A store rising edge saves all parameters; they return at next power-up.
// RULE7: A store takes 30 ms with normal operation halted and ready low.
// RULE8: After power-up ready stays low about one second, then goes high.
// RULE9: Alarm rises when the difference leaves the tolerance band either way.
// RULE10: Loss-of-sync rises when the correction is at its limit and sync fails.
// RULE11: Marker-in-window shows the slave marker fell inside the window.
// RULE12: On RS485 the host waits 32 ms at 600 baud down to 2 ms at 9600 baud.
// RULE13: Dialogues on the two serial ports never overlap.
// RULE14: Register access travels in framed message exchanges.
// RULE15: Each encoder's counting direction can be reversed by a setting.
// RULE16: Trim moves one increment every N cycles of 100 us, N from 1 to 999.
// RULE17: Every asynchronous input passes two flip-flops before use.
`timescale 1ns/1ns
module scc_control_io #(
  parameter int TICK_CYC   = scc_pkg::TICK_CYC,
  parameter int STORE_CYC  = scc_pkg::STORE_CYC,
  parameter int SETTLE_CYC = scc_pkg::SETTLE_CYC
) (
  input  wire logic        core_clk,        // 125 MHz clock
  input  wire logic        rst,             // Synchronous reset, power-up
  input  wire logic [4:0]  addr,            // Register index
  input  wire logic [15:0] wdata,           // Write data
  input  wire logic        wr,              // Write strobe
  input  wire logic        rd,              // Read strobe
  output logic      [15:0] rdata,           // Read data, cycle after rd
  input  wire logic        trim_adv_pin,    // Phase advance
  input  wire logic        trim_ret_pin,    // Phase retard
  input  wire logic        mark_master_pin, // Master marker
  input  wire logic        mark_slave_pin,  // Slave marker
  input  wire logic        diff_reset_pin,  // Difference counter reset
  input  wire logic        store_pin,       // Store parameters
  input  wire logic        master_enc_a,    // Master encoder channel A
  input  wire logic        master_enc_b,    // Master encoder channel B
  input  wire logic        slave_enc_a,     // Slave encoder channel A
  input  wire logic        slave_enc_b,     // Slave encoder channel B
  output logic      [15:0] corr_out,        // Signed correction value
  output logic             ready,           // Ready to run
  output logic             alarm,           // Out of tolerance
  output logic             lost_sync,       // Sync lost at full correction
  output logic             mark_in_window,  // Slave marker in window
  output logic             irq              // Interrupt, level
);
  typedef struct packed {
    scc_pkg::scc_fsm_t  st;
    logic [26:0]        cnt;
    logic [13:0]        tick_cnt;
    logic [15:0]        trim_cnt;
    logic [7:0][15:0]   prm;
    logic               sig_ok;
    logic               mm_d;
    logic               ms_d;
    logic               store_d;
    logic [1:0]         enc_m;
    logic [1:0]         enc_s;
    logic [23:0]        diff;
    logic [23:0]        mpos;
    logic [15:0]        corr;
    logic               ready;
    logic               alarm;
    logic               lost;
    logic               in_win;
    logic [3:0]         irq_st;
    logic [3:0]         irq_en;
    logic               irq;
    logic [15:0]        rdata;
  } scc_state_t;
  scc_state_t s, next_s;

  logic [9:0]  pins;
  logic [15:0] mem_rdata;
  logic        mem_we;
  logic [3:0]  mem_waddr;
  logic [15:0] mem_wdata;
  logic [3:0]  mem_raddr;
  logic        tick;
  logic        trim_step;
  logic        trim_act;
  logic        ratio_mode;
  logic        mm_edge;
  logic        ms_edge;
  logic        store_req;
  logic [1:0]  dm;
  logic [1:0]  ds;
  logic [15:0] trim_n;
  logic [23:0] mag_d;
  logic [23:0] err;
  logic [23:0] lim;
  logic [3:0]  ev;

  // Quadrature step: +1, -1 or 0, negated when reversed
  function automatic logic [1:0] qdec(input logic [1:0] p, input logic [1:0] c,
                                      input logic rev);
    logic [1:0] r;
    r = 2'h0;
    case ({p, c})
      4'h1, 4'h7, 4'hE, 4'h8: r = 2'h1;
      4'h2, 4'hB, 4'hD, 4'h4: r = 2'h3;
      default:                r = 2'h0;
    endcase
    return rev ? 2'(-r) : r;
  endfunction : qdec

  function automatic logic [23:0] mag(input logic [23:0] v);
    return v[23] ? 24'(-v) : v;
  endfunction : mag

  function automatic logic [23:0] sx2(input logic [1:0] v);
    return {{22{v[1]}}, v};
  endfunction : sx2

  ////////////////////////////////////////////////////////////////////////
  // Pin synchroniser and parameter store
  scc_sync #(.W(scc_pkg::NPIN)) u_sync (               // see RULE17
    .core_clk (core_clk),
    .rst      (rst),
    .din      ({slave_enc_a, slave_enc_b, master_enc_a, master_enc_b, store_pin,
                diff_reset_pin, mark_slave_pin, mark_master_pin, trim_ret_pin,
                trim_adv_pin}),
    .dout     (pins)
  );

  scc_nvmem u_mem (
    .core_clk (core_clk),
    .we       (mem_we),
    .waddr    (mem_waddr),
    .wdata    (mem_wdata),
    .raddr    (mem_raddr),
    .rdata    (mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    next_s     = s;
    ev         = 4'h0;
    mem_we     = 1'b0;
    mem_waddr  = s.cnt[3:0];
    mem_wdata  = (s.cnt[3:0] == scc_pkg::SIG_ADDR) ? scc_pkg::STORE_SIG : s.prm[s.cnt[2:0]];
    mem_raddr  = (s.cnt[3:0] == 4'h0) ? scc_pkg::SIG_ADDR : 4'(s.cnt[3:0] - 4'h1);
    ratio_mode = s.prm[scc_pkg::P_CTRL][2:0] == scc_pkg::MODE_RATIO;
    // Inputs are only sampled after the synchroniser; held 1 ms by the controller
    mm_edge    = pins[2] & ~s.mm_d & s.prm[scc_pkg::P_CTRL][scc_pkg::C_MARK_EN]; // see RULE3
    ms_edge    = pins[3] & ~s.ms_d & s.prm[scc_pkg::P_CTRL][scc_pkg::C_MARK_EN]; // see RULE3
    store_req  = (pins[5] & ~s.store_d)                                          // see RULE6
                 | (wr && addr == scc_pkg::R_CMD && wdata[0]);
    next_s.mm_d    = pins[2];
    next_s.ms_d    = pins[3];
    next_s.store_d = pins[5];
    next_s.enc_m   = pins[7:6];
    next_s.enc_s   = pins[9:8];
    dm = qdec(s.enc_m, pins[7:6], s.prm[scc_pkg::P_CTRL][scc_pkg::C_MREV]); // see RULE15
    ds = qdec(s.enc_s, pins[9:8], s.prm[scc_pkg::P_CTRL][scc_pkg::C_SREV]); // see RULE15

    // 100 us processing tick and trim pacing
    tick = s.tick_cnt == 14'(TICK_CYC - 1);
    next_s.tick_cnt = tick ? 14'h0000 : 14'(s.tick_cnt + 14'h0001);
    trim_n = s.prm[scc_pkg::P_TRIM];
    if (trim_n < scc_pkg::TRIM_MIN) begin
      trim_n = scc_pkg::TRIM_MIN;
    end else if (trim_n > scc_pkg::TRIM_MAX) begin
      trim_n = scc_pkg::TRIM_MAX;
    end
    trim_act = ratio_mode ? ((pins[2] | pins[3]) & s.prm[scc_pkg::P_CTRL][scc_pkg::C_MARK_EN])
                          : (pins[0] | pins[1]);
    trim_step = 1'b0;
    if (!trim_act) begin
      next_s.trim_cnt = 16'h0000;
    end else if (tick) begin
      if (16'(s.trim_cnt + 16'h0001) >= trim_n) begin                  // see RULE16
        trim_step       = 1'b1;
        next_s.trim_cnt = 16'h0000;
      end else begin
        next_s.trim_cnt = 16'(s.trim_cnt + 16'h0001);
      end
    end

    // Difference counter, correction and markers while running
    lim   = {9'h000, s.prm[scc_pkg::P_LIMIT][14:0]};
    mag_d = mag(s.diff);
    err   = 24'(s.diff - s.mpos - {{8{s.prm[scc_pkg::P_PHASE][15]}}, s.prm[scc_pkg::P_PHASE]});
    if (pins[4] || s.st != scc_pkg::ST_RUN && s.st != scc_pkg::ST_STORE) begin
      next_s.diff = 24'h000000;                                         // see RULE5
      next_s.corr = 16'h0000;                                           // see RULE5
    end else if (s.st == scc_pkg::ST_RUN) begin
      next_s.diff = 24'(s.diff + sx2(dm) - sx2(ds));
      if (trim_step && !ratio_mode) begin
        if (pins[0] && !pins[1]) begin
          next_s.diff = 24'(next_s.diff - 24'h000001);                  // see RULE2
        end else if (pins[1] && !pins[0]) begin
          next_s.diff = 24'(next_s.diff + 24'h000001);                  // see RULE2
        end
      end
      if (mag_d > lim) begin
        next_s.corr = s.diff[23] ? 16'(-lim) : lim[15:0];
      end else begin
        next_s.corr = s.diff[15:0];
      end
      if (!ratio_mode && mm_edge) begin
        next_s.mpos = s.diff;
      end
      if (!ratio_mode && ms_edge) begin
        next_s.in_win = mag(err) <= {8'h00, s.prm[scc_pkg::P_WIN]};     // see RULE11
        ev[scc_pkg::I_MARK] = 1'b1;
      end
      if (ratio_mode && trim_step) begin
        if (pins[2] && !pins[3] && s.prm[scc_pkg::P_FACTOR] != 16'hFFFF) begin
          next_s.prm[scc_pkg::P_FACTOR] = 16'(s.prm[scc_pkg::P_FACTOR] + 16'h0001); // see RULE4
        end else if (pins[3] && !pins[2] && s.prm[scc_pkg::P_FACTOR] > 16'h0001) begin
          next_s.prm[scc_pkg::P_FACTOR] = 16'(s.prm[scc_pkg::P_FACTOR] - 16'h0001); // see RULE4
        end
      end
    end
    next_s.alarm = s.st == scc_pkg::ST_RUN                              // see RULE9
                   && mag_d > {8'h00, s.prm[scc_pkg::P_TOL]};
    next_s.lost  = s.st == scc_pkg::ST_RUN && mag_d > lim               // see RULE10
                   && mag_d > {8'h00, s.prm[scc_pkg::P_TOL]};
    ev[scc_pkg::I_ALARM] = next_s.alarm & ~s.alarm;
    ev[scc_pkg::I_LOST]  = next_s.lost & ~s.lost;

    // Register writes, framed upstream by the serial layer
    if (wr && s.st != scc_pkg::ST_BOOT) begin                           // see RULE14
      if (!addr[4] && !addr[3]) begin
        next_s.prm[addr[2:0]] = wdata;
      end else if (addr == scc_pkg::R_IRQ_EN) begin
        next_s.irq_en = wdata[3:0];
      end
    end

    // Sequencer: restore, settle, run, store
    case (s.st)
      scc_pkg::ST_BOOT: begin
        next_s.cnt = 27'(s.cnt + 27'h1);
        if (s.cnt[3:0] == 4'h1) begin
          next_s.sig_ok = mem_rdata == scc_pkg::STORE_SIG;
        end else if (s.cnt[3:0] >= 4'h2 && s.sig_ok) begin
          next_s.prm[3'(s.cnt[3:0] - 4'h2)] = mem_rdata;               // see RULE6
        end
        if (s.cnt[3:0] == scc_pkg::BOOT_LAST) begin
          next_s.st  = scc_pkg::ST_SETTLE;
          next_s.cnt = 27'h0;
        end
      end
      scc_pkg::ST_SETTLE: begin
        next_s.cnt = 27'(s.cnt + 27'h1);
        if (s.cnt == 27'(SETTLE_CYC - 1)) begin                          // see RULE8
          next_s.st  = scc_pkg::ST_RUN;
          next_s.cnt = 27'h0;
        end
      end
      scc_pkg::ST_RUN: begin
        if (store_req) begin
          next_s.st  = scc_pkg::ST_STORE;
          next_s.cnt = 27'h0;
        end
      end
      scc_pkg::ST_STORE: begin
        mem_we     = s.cnt <= 27'(scc_pkg::SIG_ADDR);                    // see RULE6
        next_s.cnt = 27'(s.cnt + 27'h1);
        if (s.cnt == 27'(STORE_CYC - 1)) begin                           // see RULE7
          next_s.st  = scc_pkg::ST_RUN;
          next_s.cnt = 27'h0;
          ev[scc_pkg::I_STORE] = 1'b1;
        end
      end
      default: begin
        next_s.st  = scc_pkg::ST_BOOT;
        next_s.cnt = 27'h0;
      end
    endcase
    next_s.ready = next_s.st == scc_pkg::ST_RUN;                        // see RULE7

    // Sticky status: a new event wins over a clear
    next_s.irq_st = s.irq_st;
    if (wr && addr == scc_pkg::R_IRQ_CLR) begin
      next_s.irq_st = s.irq_st & ~wdata[3:0];
    end
    next_s.irq_st = next_s.irq_st | ev;
    next_s.irq    = |(next_s.irq_st & next_s.irq_en);

    // Read data valid only in the cycle after the strobe
    next_s.rdata = 16'h0000;
    if (rd) begin
      if (!addr[4] && !addr[3]) begin
        next_s.rdata = s.prm[addr[2:0]];
      end else begin
        case (addr)
          scc_pkg::R_STATUS: next_s.rdata = {11'h000, s.st == scc_pkg::ST_STORE, s.in_win,
                                             s.lost, s.alarm, s.ready};
          scc_pkg::R_DIFF:   next_s.rdata = s.diff[15:0];
          scc_pkg::R_IRQ_ST: next_s.rdata = {12'h000, s.irq_st};
          scc_pkg::R_IRQ_EN: next_s.rdata = {12'h000, s.irq_en};
          default:           next_s.rdata = 16'h0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s     <= '0;
      s.st  <= scc_pkg::ST_BOOT;
      s.prm <= scc_pkg::PRM_DEF;
    end else begin
      s <= next_s;
    end
  end

  assign rdata          = s.rdata;
  assign corr_out       = s.corr;
  assign ready          = s.ready;
  assign alarm          = s.alarm;
  assign lost_sync      = s.lost;
  assign mark_in_window = s.in_win;
  assign irq            = s.irq;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence seq_store_start;
    s.st == scc_pkg::ST_RUN && store_req;
  endsequence
  sequence seq_ready_low8;
    (!ready)[*8];
  endsequence

  a_store_ready_low: assert property (seq_store_start |=> seq_ready_low8) // see RULE7
    else $error("ready not low at start of store");
  a_store_holds: assert property ( // see RULE7
    s.st == scc_pkg::ST_STORE && s.cnt < 27'(STORE_CYC - 1) |=> s.st == scc_pkg::ST_STORE)
    else $error("store ended early");
  a_settle_ready: assert property ( // see RULE8
    s.st == scc_pkg::ST_SETTLE && s.cnt < 27'(SETTLE_CYC - 1) |=> !ready)
    else $error("ready high while settling");
  a_reset_clears: assert property (pins[4] |=> s.diff == 24'h0 && corr_out == 16'h0) // see RULE5
    else $error("reset input did not clear difference");
  a_alarm_band: assert property ( // see RULE9
    s.st == scc_pkg::ST_RUN && mag(s.diff) > {8'h00, s.prm[scc_pkg::P_TOL]} |=> alarm)
    else $error("alarm missing outside tolerance");
  a_lost_limit: assert property (lost_sync |-> $past(mag(s.diff)) > $past(lim)) // see RULE10
    else $error("loss of sync without full correction");
  a_marker_edge: assert property (!ms_edge |=> $stable(mark_in_window)) // see RULE3
    else $error("window flag moved without slave edge");
  a_trim_advance: assert property ( // see RULE2
    s.st == scc_pkg::ST_RUN && trim_step && !ratio_mode && pins[0] && !pins[1]
    && !pins[4] && dm == 2'h0 && ds == 2'h0 |=> s.diff == 24'($past(s.diff) - 24'h1))
    else $error("advance trim did not move phase");
  a_ratio_inc: assert property ( // see RULE4
    s.st == scc_pkg::ST_RUN && ratio_mode && trim_step && pins[2] && !pins[3] && !wr
    && s.prm[scc_pkg::P_FACTOR] != 16'hFFFF
    |=> s.prm[scc_pkg::P_FACTOR] == 16'($past(s.prm[scc_pkg::P_FACTOR]) + 16'h1))
    else $error("ratio factor not raised");
  a_trim_pace: assert property (trim_step |-> tick && 16'(s.trim_cnt + 16'h1) >= trim_n) // see RULE16
    else $error("trim step off its period");
endmodule : scc_control_io

// >>> dv/scc_plc_model.sv
// Command pin and encoder driver standing for the controlling PLC
`timescale 1ns/1ns
module scc_plc_model #(
  parameter int HOLD = 40 // Command hold in cycles, shortened for simulation
) (
  input  wire logic       core_clk, // System clock
  output logic      [5:0] cmd,      // Command pins
  output logic      [1:0] menc,     // Master encoder {a,b}
  output logic      [1:0] senc      // Slave encoder {a,b}
);
  // Idle levels at time zero
  initial begin
    cmd  = 6'h00;
    menc = 2'h0;
    senc = 2'h0;
  end
  // Change one command level, then keep it steady
  task automatic set_cmd(input int i, input logic v);
    @(posedge core_clk);
    cmd[i] <= v;
    repeat (HOLD) @(posedge core_clk);
  endtask : set_cmd
  // Forward quadrature steps 00 01 11 10, five cycles apart
  task automatic step(input logic slv, input int n);
    logic [1:0] g;
    for (int k = 0; k < n; k++) begin
      g = slv ? senc : menc;
      @(posedge core_clk);
      if (slv) senc <= {g[0], ~g[1]};
      else menc <= {g[0], ~g[1]};
      repeat (4) @(posedge core_clk);
    end
  endtask : step
endmodule : scc_plc_model

// >>> dv/testbench.sv
// Register and pin level tests of the synchroniser control I/O block
`timescale 1ns/1ns
module testbench;
  logic        core_clk = 1'b0;
  logic        rst      = 1'b1;
  logic [4:0]  addr     = 5'h00;
  logic [15:0] wdata    = 16'h0000;
  logic        wr       = 1'b0;
  logic        rd       = 1'b0;
  logic [15:0] rdata;
  logic [15:0] corr_out;
  logic        ready;
  logic        alarm;
  logic        lost_sync;
  logic        mark_in_window;
  logic        irq;
  logic [5:0]  cmd;
  logic [1:0]  menc;
  logic [1:0]  senc;
  logic [15:0] d;
  int          miscompares = 0;
  int          tests_run   = 0;
  int          cyc         = 0;
  ////////////////////////////////////////////////////////////////////////////////
  // Clock, 8 ns period
  always #4 core_clk = ~core_clk;
  scc_control_io #(.TICK_CYC(10), .STORE_CYC(20), .SETTLE_CYC(30)) u_scc_control_io (
    .core_clk(core_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .trim_adv_pin(cmd[0]), .trim_ret_pin(cmd[1]),
    .mark_master_pin(cmd[2]), .mark_slave_pin(cmd[3]), .diff_reset_pin(cmd[4]),
    .store_pin(cmd[5]), .master_enc_a(menc[1]), .master_enc_b(menc[0]),
    .slave_enc_a(senc[1]), .slave_enc_b(senc[0]), .corr_out(corr_out), .ready(ready),
    .alarm(alarm), .lost_sync(lost_sync), .mark_in_window(mark_in_window), .irq(irq));
  scc_plc_model u_scc_plc_model (.core_clk(core_clk), .cmd(cmd), .menc(menc), .senc(senc));
  ////////////////////////////////////////////////////////////////////////////////
  // Closing report
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up
  // Hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      wrap_up();
    end
  end
  // Value compare
  task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %0t %s got %h expected %h", $time, m, g, e);
    end
  endtask : chk
  // Bus write, one cycle; each access ends before the next
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] v);
    @(posedge core_clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= v;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask : wr_reg
  // Bus read, data in the following cycle; one access at a time
  task automatic rd_reg(input logic [4:0] a, output logic [15:0] v);
    @(posedge core_clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rd_reg
  // Reset for five cycles, then ready must be low 25 cycles on and high within 50 more
  task automatic do_rst();
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    repeat (25) @(posedge core_clk);
    #1 chk({15'h0, ready}, 16'h0000, "ready early");
    for (int k = 0; k < 50 && ready !== 1'b1; k++) @(posedge core_clk);
    #1 chk({15'h0, ready}, 16'h0001, "ready late");
  endtask : do_rst
  task automatic pulse(input int i);
    u_scc_plc_model.set_cmd(i, 1'b1);
    u_scc_plc_model.set_cmd(i, 1'b0);
  endtask : pulse
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    do_rst();
    for (int k = 0; k < 8; k++) begin
      rd_reg(k[4:0], d);
      chk(d, scc_pkg::PRM_DEF[k], "default");
    end
    rd_reg(5'h1F, d);
    chk(d, 16'h0000, "unmapped");
    $display("reset test done");
    wr_reg(5'h03, 16'h0002);
    wr_reg(5'h06, 16'h0003);
    wr_reg(scc_pkg::R_IRQ_EN, 16'h0001);
    u_scc_plc_model.step(1'b0, 4);
    rd_reg(scc_pkg::R_DIFF, d);
    chk(d, 16'h0004, "diff count");
    chk({13'h0, lost_sync, alarm, irq}, 16'h0007, "alarm lost irq");
    chk(corr_out, 16'h0003, "corr clamp");
    wr_reg(scc_pkg::R_IRQ_CLR, 16'h0001);
    @(posedge core_clk);
    #1 chk({15'h0, irq}, 16'h0000, "irq clear");
    $display("alarm test done");
    u_scc_plc_model.set_cmd(4, 1'b1);
    u_scc_plc_model.step(1'b0, 2);
    rd_reg(scc_pkg::R_DIFF, d);
    chk(d, 16'h0000, "diff held");
    chk(corr_out, 16'h0000, "corr held");
    u_scc_plc_model.set_cmd(4, 1'b0);
    pulse(0);
    rd_reg(scc_pkg::R_DIFF, d);
    chk({15'h0, d[15]}, 16'h0001, "advance sign");
    pulse(4);
    pulse(1);
    rd_reg(scc_pkg::R_DIFF, d);
    chk({15'h0, d[15] == 1'b0 && d != 16'h0}, 16'h0001, "retard sign");
    pulse(4);
    wr_reg(5'h00, 16'h0010);
    u_scc_plc_model.step(1'b0, 4);
    rd_reg(scc_pkg::R_DIFF, d);
    chk(d, 16'hFFFC, "reversed");
    $display("trim test done");
    wr_reg(5'h00, 16'h0000);
    pulse(2);
    pulse(3);
    rd_reg(scc_pkg::R_IRQ_ST, d);
    chk({15'h0, d[2]}, 16'h0000, "marker off");
    wr_reg(5'h00, 16'h0008);
    pulse(2);
    pulse(3);
    rd_reg(scc_pkg::R_IRQ_ST, d);
    chk({14'h0, mark_in_window, d[2]}, 16'h0003, "marker on");
    wr_reg(5'h00, 16'h000C);
    pulse(2);
    rd_reg(5'h01, d);
    chk({15'h0, d > 16'h2710}, 16'h0001, "factor up");
    $display("marker test done");
    wr_reg(5'h00, 16'h0000);
    wr_reg(5'h03, 16'h0007);
    fork
      u_scc_plc_model.set_cmd(5, 1'b1);
      begin
        repeat (8) @(posedge core_clk);
        #1 chk({15'h0, ready}, 16'h0000, "store busy");
      end
    join
    u_scc_plc_model.set_cmd(5, 1'b0);
    #1 chk({15'h0, ready}, 16'h0001, "store end");
    rd_reg(scc_pkg::R_IRQ_ST, d);
    chk({15'h0, d[3]}, 16'h0001, "store done");
    wr_reg(scc_pkg::R_CMD, 16'h0001);
    rd_reg(scc_pkg::R_STATUS, d);
    chk({14'h0, d[4], d[0]}, 16'h0002, "command store busy");
    repeat (30) @(posedge core_clk);
    #1 chk({15'h0, ready}, 16'h0001, "command store end");
    wr_reg(5'h03, 16'h0009);
    do_rst();
    rd_reg(5'h03, d);
    chk(d, 16'h0007, "restored");
    $display("store test done");
    wrap_up();
  end
endmodule : testbench
